// [logic/hs_switch_pkg.sv]
package hs_switch_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; the byte address is four times the index
    localparam logic [7:0] TIMER_B_IDX = 8'h0D;
    localparam logic [7:0] SHUTDOWN_IDX = 8'h10;
    localparam logic [7:0] SRC_LO_IDX = 8'h14;
    localparam logic [7:0] SRC_HI_IDX = 8'h15;
    localparam int ADDR_W = 8;

    // field positions
    localparam int ON_LSB = 4;
    localparam int PER_LSB = 0;
    localparam int OV_DIS_BIT = 6;
    localparam int UV_DIS_BIT = 5;
    localparam int REC_BIT = 4;
    localparam int FIELD_STRIDE = 4;
    localparam logic [7:0] REG_RESET = 8'h00;

    // on-time codes that stop the timer
    localparam logic [2:0] ON_LOW = 3'h0;
    localparam logic [2:0] ON_HIGH = 3'h6;
    localparam logic [2:0] CODE_RSVD = 3'h7;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // timing: one base tick is 0.1 ms
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_US = 100;
    localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int ON_A_US = 100;
    localparam int ON_B_US = 300;
    localparam int ON_C_US = 1000;
    localparam int ON_D_US = 10000;
    localparam int ON_E_US = 20000;
    localparam int PER_A_MS = 10;
    localparam int PER_B_MS = 20;
    localparam int PER_C_MS = 50;
    localparam int PER_D_MS = 100;
    localparam int PER_E_MS = 200;
    localparam int PER_F_MS = 1000;
    localparam int PER_G_MS = 2000;
    localparam int TCNT_W = 15;

    typedef enum logic [2:0] {
        SRC_OFF = 3'h0,
        SRC_ON = 3'h1,
        SRC_T1 = 3'h2,
        SRC_T2 = 3'h3,
        SRC_FIRST_PWM_CHANNEL = 3'h4,
        SRC_SECOND_PWM_CHANNEL = 3'h5
    } src_t;

    typedef struct packed {
        logic [2:0] on_time;
        logic [2:0] period;
    } timer_ctrl_t;

    typedef struct packed {
        logic ov_dis;
        logic uv_dis;
        logic recover;
    } shutdown_ctrl_t;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {idx[5:0], 2'h0};
    endfunction

    // on duration in ticks, zero where the timer does not run
    function automatic logic [TCNT_W-1:0] on_ticks(input logic [2:0] code);
        case (code)
            3'h1: return TCNT_W'(ON_A_US / TICK_TIME_US);
            3'h2: return TCNT_W'(ON_B_US / TICK_TIME_US);
            3'h3: return TCNT_W'(ON_C_US / TICK_TIME_US);
            3'h4: return TCNT_W'(ON_D_US / TICK_TIME_US);
            3'h5: return TCNT_W'(ON_E_US / TICK_TIME_US);
            default: return '0;
        endcase
    endfunction

    // period in ticks, zero for the reserved code
    function automatic logic [TCNT_W-1:0] per_ticks(input logic [2:0] code);
        case (code)
            3'h0: return TCNT_W'(PER_A_MS * 1000 / TICK_TIME_US);
            3'h1: return TCNT_W'(PER_B_MS * 1000 / TICK_TIME_US);
            3'h2: return TCNT_W'(PER_C_MS * 1000 / TICK_TIME_US);
            3'h3: return TCNT_W'(PER_D_MS * 1000 / TICK_TIME_US);
            3'h4: return TCNT_W'(PER_E_MS * 1000 / TICK_TIME_US);
            3'h5: return TCNT_W'(PER_F_MS * 1000 / TICK_TIME_US);
            3'h6: return TCNT_W'(PER_G_MS * 1000 / TICK_TIME_US);
            default: return '0;
        endcase
    endfunction

endpackage

// [logic/tick_divider.sv]
module tick_divider import hs_switch_pkg::*; #(
    parameter int DIV = TICK_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // one-cycle enable every DIV cycles
    output logic tick
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] cnt_reg;

    if (DIV < 1) begin : g_bad_div
        $error("divider must be at least one");
    end

    // free-running count, tick on wrap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= '0;
        end else if (cnt_reg == CW'(DIV - 1)) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick = (cnt_reg == CW'(DIV - 1));
endmodule // tick_divider

// [logic/cyclic_timer.sv]
module cyclic_timer import hs_switch_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic tick,
    input wire logic restart,
    input wire timer_ctrl_t cfg,
    // timer output
    output logic timer_out
);
    logic [TCNT_W-1:0] cnt_reg;
    logic running;
    logic [TCNT_W-1:0] on_len;
    logic [TCNT_W-1:0] per_len;

    assign on_len = on_ticks(cfg.on_time);
    assign per_len = per_ticks(cfg.period);
    // reserved codes leave the timer stopped
    assign running = (on_len != '0) && (per_len != '0);

    ////////////////////////////////////////////////////////////////////////////
    // position within the period, restarted by every setting write
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || !running) begin
            cnt_reg <= '0;
        end else if (tick) begin
            cnt_reg <= (cnt_reg == per_len - 1'b1) ? '0 : cnt_reg + 1'b1;
        end
    end

    // high during the on-time at the head of each period
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_out <= 1'b0;
        end else if (cfg.on_time == ON_HIGH) begin
            timer_out <= 1'b1;
        end else if (!running) begin
            timer_out <= 1'b0;
        end else begin
            timer_out <= (cnt_reg < on_len);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_period_wrap: assert property (running && !restart && tick && cnt_reg == per_len - 1'b1
        |=> cnt_reg == '0) else $error("period count did not wrap");
    a_on_head: assert property (running && $stable(cfg) && cnt_reg == '0 && on_len != '0
        |=> timer_out) else $error("timer low at start of period");
    a_on_end: assert property (running && $stable(cfg) && cnt_reg == on_len && on_len < per_len
        |=> !timer_out) else $error("timer high after on-time");
    c_timer_pulse: cover property (running ##1 $rose(timer_out));
endmodule // cyclic_timer

// [logic/high_side_switch_control.sv]
// Chosen here: register access over AXI4-Lite.
module high_side_switch_control import hs_switch_pkg::*; #(
    parameter int TICK_DIV = TICK_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // chip mode events
    input wire logic soft_reset,
    input wire logic restart_mode,
    input wire logic cyclic_sense_active,
    // switch supply and switch faults
    input wire logic supply_ov,
    input wire logic supply_uv,
    input wire logic [3:0] overcurrent,
    input wire logic [3:0] overtemp,
    // other drive sources
    input wire logic first_cyclic_timer,
    input wire logic first_pwm_channel,
    input wire logic second_pwm_channel,
    // switch drive
    output logic [3:0] switch_output,
    output logic second_cyclic_timer
);
    if (TICK_DIV < 1) begin : g_bad_tick
        $error("tick divider must be at least one");
    end

    timer_ctrl_t timer_reg;
    shutdown_ctrl_t shutdown_reg;
    src_t src_reg [4];
    logic aw_held_reg, w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic aw_have, w_have, wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_timer, wr_sd, wr_lo, wr_hi;
    logic fault_active, fault_prev_reg, fault_entry, clear_all;
    logic tick;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a == reg_addr(TIMER_B_IDX) || a == reg_addr(SHUTDOWN_IDX)
            || a == reg_addr(SRC_LO_IDX) || a == reg_addr(SRC_HI_IDX);
    endfunction

    // register image; reserved positions stay zero
    function automatic logic [7:0] read_reg(input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = '0;
        if (a == reg_addr(TIMER_B_IDX)) begin
            v[ON_LSB +: 3] = timer_reg.on_time;
            v[PER_LSB +: 3] = timer_reg.period;
        end else if (a == reg_addr(SHUTDOWN_IDX)) begin
            v[OV_DIS_BIT] = shutdown_reg.ov_dis;
            v[UV_DIS_BIT] = shutdown_reg.uv_dis;
            v[REC_BIT] = shutdown_reg.recover;
        end else if (a == reg_addr(SRC_LO_IDX)) begin
            v[0 +: 3] = src_reg[0];
            v[FIELD_STRIDE +: 3] = src_reg[1];
        end else if (a == reg_addr(SRC_HI_IDX)) begin
            v[0 +: 3] = src_reg[2];
            v[FIELD_STRIDE +: 3] = src_reg[3];
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // write address and data are taken in either order, then answered
    assign awready = !aw_held_reg && !bvalid;
    assign wready = !w_held_reg && !bvalid;
    assign aw_have = aw_held_reg || (awvalid && awready);
    assign w_have = w_held_reg || (wvalid && wready);
    assign wr_fire = aw_have && w_have && !bvalid;
    assign wr_addr = aw_held_reg ? awaddr_reg : awaddr;
    assign wr_data = w_held_reg ? wdata_reg : wdata;
    assign wr_strb = w_held_reg ? wstrb_reg : wstrb;
    // only byte lane 0 carries register bits
    assign wr_timer = wr_fire && wr_strb[0] && wr_addr == reg_addr(TIMER_B_IDX);
    assign wr_sd = wr_fire && wr_strb[0] && wr_addr == reg_addr(SHUTDOWN_IDX);
    assign wr_lo = wr_fire && wr_strb[0] && wr_addr == reg_addr(SRC_LO_IDX);
    assign wr_hi = wr_fire && wr_strb[0] && wr_addr == reg_addr(SRC_HI_IDX);

    // hold whichever half arrived first
    always_ff @(posedge aclk) begin
        if (!aresetn || wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (awvalid && awready) begin
            awaddr_reg <= awaddr;
        end
        if (wvalid && wready) begin
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp <= is_mapped(wr_addr) ? RESP_OKAY : RESP_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read answer one cycle after the address is taken
    assign arready = !rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= {24'h000000, read_reg(araddr)};
            rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // supply fault shutdown, gated per direction by the disable bits
    assign fault_active = (supply_ov && !shutdown_reg.ov_dis)
        || (supply_uv && !shutdown_reg.uv_dis);
    assign fault_entry = fault_active && !fault_prev_reg;
    assign clear_all = soft_reset || restart_mode;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_prev_reg <= 1'b0;
        end else begin
            fault_prev_reg <= fault_active;
        end
    end

    // shutdown control survives restart in bits 6:4
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset) begin
            shutdown_reg <= '0;
        end else if (wr_sd) begin
            shutdown_reg.ov_dis <= wr_data[OV_DIS_BIT];
            shutdown_reg.uv_dis <= wr_data[UV_DIS_BIT];
            shutdown_reg.recover <= wr_data[REC_BIT];
        end
    end

    // timer settings; restart clears them together with the sources
    always_ff @(posedge aclk) begin
        if (!aresetn || clear_all || (restart_mode && cyclic_sense_active)) begin
            timer_reg <= '0;
        end else if (wr_timer) begin
            timer_reg.on_time <= wr_data[ON_LSB +: 3];
            timer_reg.period <= wr_data[PER_LSB +: 3];
        end
    end

    // source fields; a fault clear beats a software write in the same cycle
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 4; i++) begin
            if (!aresetn || clear_all) begin
                src_reg[i] <= SRC_OFF;
            end else if (overcurrent[i] || overtemp[i]) begin
                src_reg[i] <= SRC_OFF;
            end else if (fault_entry && !shutdown_reg.recover) begin
                src_reg[i] <= SRC_OFF;
            end else if ((i < 2) ? wr_lo : wr_hi) begin
                src_reg[i] <= src_t'(wr_data[(i % 2) * FIELD_STRIDE +: 3]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    tick_divider #(
        .DIV(TICK_DIV)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    // every setting write restarts the period from its head
    cyclic_timer u_timer_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .restart(wr_timer),
        .cfg(timer_reg),
        .timer_out(second_cyclic_timer)
    );

    // source mux; reserved codes drive low, supply faults force every switch off
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 4; i++) begin
            if (!aresetn || fault_active) begin
                switch_output[i] <= 1'b0;
            end else begin
                case (src_reg[i])
                    SRC_ON: switch_output[i] <= 1'b1;
                    SRC_T1: switch_output[i] <= first_cyclic_timer;
                    SRC_T2: switch_output[i] <= second_cyclic_timer;
                    SRC_FIRST_PWM_CHANNEL: switch_output[i] <= first_pwm_channel;
                    SRC_SECOND_PWM_CHANNEL: switch_output[i] <= second_pwm_channel;
                    default: switch_output[i] <= 1'b0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_ov_shutdown_off: assert property (supply_ov && !shutdown_reg.ov_dis
        |=> switch_output == 4'h0) else $error("switch on during overvoltage");
    a_uv_shutdown_off: assert property (supply_uv && !shutdown_reg.uv_dis
        |=> switch_output == 4'h0) else $error("switch on during undervoltage");
    a_fault_no_recover: assert property (fault_entry && !shutdown_reg.recover
        |=> src_reg[0] == SRC_OFF && src_reg[3] == SRC_OFF)
        else $error("source kept after fault");
    a_fault_recover: assert property (fault_active && shutdown_reg.recover && !wr_lo
        && !clear_all && overcurrent == 4'h0 && overtemp == 4'h0
        |=> src_reg[0] == $past(src_reg[0])) else $error("source lost with recovery");
    a_oc_clears_src: assert property (overcurrent[1] || overtemp[1]
        |=> src_reg[1] == SRC_OFF) else $error("fault did not clear source");
    a_timer_low_hold: assert property ((timer_reg.on_time == ON_LOW)[*2]
        |-> !second_cyclic_timer) else $error("timer high with on-time off");
    a_timer_high_hold: assert property ((timer_reg.on_time == ON_HIGH)[*2]
        |-> second_cyclic_timer) else $error("timer low with on-time high");
    a_restart_clear: assert property (restart_mode && !soft_reset && !wr_sd
        |=> timer_reg == '0 && src_reg[2] == SRC_OFF && shutdown_reg == $past(shutdown_reg))
        else $error("restart values wrong");
    a_reserved_zero: assert property (rvalid |-> rdata[31:7] == '0 && rdata[3] == 1'b0)
        else $error("reserved bits read nonzero");
    a_src_on_drive: assert property (src_reg[2] == SRC_ON && !fault_active
        |=> switch_output[2]) else $error("switch off with source on");
    a_write_lo: assert property (wr_lo && !clear_all && !fault_active
        && overcurrent == 4'h0 && overtemp == 4'h0
        |=> src_reg[1] == $past(wr_data[6:4])) else $error("high field misplaced");
    a_write_hi: assert property (wr_hi && !clear_all && !fault_active
        && overcurrent == 4'h0 && overtemp == 4'h0
        |=> src_reg[2] == $past(wr_data[2:0])) else $error("low field misplaced");
    a_write_answer: assert property (wr_fire |=> bvalid) else $error("no write response");

    c_fault_shutdown: cover property (fault_entry ##1 !fault_active);
    c_oc_clear: cover property (src_reg[0] != SRC_OFF ##1 overcurrent[0]);
    c_timer_write: cover property (wr_timer ##1 timer_reg.on_time != ON_LOW);
endmodule // high_side_switch_control

// [verif/mcu_bus_master.sv]
module mcu_bus_master import hs_switch_pkg::*; (
    // clock
    input wire logic aclk,
    // write channels
    output logic [ADDR_W-1:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read channels
    output logic [ADDR_W-1:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready
);
    timeunit 1ns;
    timeprecision 1ps;
    int hung = 0;

    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // both write halves offered at once, each dropped at the edge it is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        {awvalid, wvalid, bready} <= 3'b111;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        resp = bresp;
        if (n == 50) hung++;
    endtask

    // read data itself is judged by the bench monitor
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 50) hung++;
    endtask
endmodule // mcu_bus_master

// [verif/test_high_side_switch_control.sv]
`define CHK(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
end

module test_high_side_switch_control import hs_switch_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    // short tick keeps the long periods affordable
    localparam int DIV = 4;
    localparam int ON_US[5] = '{100, 300, 1000, 10000, 20000};
    localparam int PER_MS[5] = '{10, 20, 50, 100, 200};
    localparam logic [7:0] A_TMR = {TIMER_B_IDX[5:0], 2'h0};
    localparam logic [7:0] A_SD = {SHUTDOWN_IDX[5:0], 2'h0};
    localparam logic [7:0] A_LO = {SRC_LO_IDX[5:0], 2'h0};
    localparam logic [7:0] A_HI = {SRC_HI_IDX[5:0], 2'h0};
    logic aclk = 0, aresetn = 0;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, overcurrent, overtemp, switch_output;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic soft_reset, restart_mode, cyclic_sense_active, supply_ov, supply_uv;
    logic first_cyclic_timer, first_pwm_channel, second_pwm_channel, second_cyclic_timer;
    logic [33:0] notes[$];
    logic [33:0] note;
    logic [15:0] seed = 16'h4868;
    int bad_count = 0, cmp_count = 0;

    high_side_switch_control #(.TICK_DIV(DIV)) uut (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .soft_reset, .restart_mode,
        .cyclic_sense_active, .supply_ov, .supply_uv, .overcurrent, .overtemp,
        .first_cyclic_timer, .first_pwm_channel, .second_pwm_channel, .switch_output,
        .second_cyclic_timer);
    mcu_bus_master mst (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rvalid, .rready);

    initial begin
        forever #5 aclk = ~aclk;
    end

    // each read answer is held against the oldest note
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            note = notes.pop_front();
            `CHK({rresp, rdata}, note)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (mst.hung != 0) bad_count++;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        notes.push_back(e);
        mst.rd(a);
        if (mst.hung != 0) wrap_up();
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        mst.wr(a, d, resp);
        if (mst.hung != 0) wrap_up();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    // cycles from here to the next rising edge of the switch
    task automatic to_rise(output int n);
        for (n = 0; n < 9000 && switch_output[0] !== 1'b0; n++) cyc(1);
        for (; n < 9000 && switch_output[0] !== 1'b1; n++) cyc(1);
        if (n >= 9000) bad_count++;
        if (n >= 9000) wrap_up();
    endtask

    initial begin
        #1ms;
        bad_count++;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int hi;
        logic x;
        {soft_reset, restart_mode, cyclic_sense_active, supply_ov, supply_uv} = '0;
        {overcurrent, overtemp} = '0;
        {first_cyclic_timer, first_pwm_channel, second_pwm_channel} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // reset values, unmapped words, reserved bits
        rd(A_TMR, '0);
        rd(A_SD, '0);
        rd(A_LO, '0);
        rd(A_HI, '0);
        rd(8'h38, {RESP_DECERR, 32'h0});
        wr(8'h3C, 8'hFF);
        `CHK(resp, RESP_DECERR)
        seed = lfsr(seed);
        wr(A_SD, seed[7:0] | 8'h8F);
        rd(A_SD, 34'(seed[7:0] & 8'h70));
        wr(A_TMR, 8'h88);
        rd(A_TMR, 34'h0);
        // every source code on every switch; hold-high timer stands in for timer two
        wr(A_TMR, 8'h60);
        for (int s = 0; s < 4; s++) begin
            // reserved codes 6 and 7 must drive the switch low
            for (int c = 7; c >= 0; c--) begin
                seed = lfsr(seed);
                @(posedge aclk);
                {first_cyclic_timer, first_pwm_channel, second_pwm_channel} <= seed[2:0];
                wr(s < 2 ? A_LO : A_HI, 8'(c << (4 * (s % 2))));
                cyc(3);
                x = c == 1 || c == 3 || (c == 2 && seed[2]) || (c == 4 && seed[1]);
                x = x || (c == 5 && seed[0]);
                `CHK(switch_output, 4'(x) << s)
            end
        end
        // switch one follows timer two: stopped low, then each on-time
        wr(A_LO, 8'h03);
        wr(A_TMR, 8'h00);
        cyc(3);
        `CHK({switch_output[0], second_cyclic_timer}, 2'b00)
        for (int c = 1; c < 6; c++) begin
            wr(A_TMR, 8'(c << 4 | 2));
            cyc(5);
            hi = 0;
            repeat (500 * DIV) begin
                cyc(1);
                if (switch_output[0] === 1'b1) hi++;
            end
            `CHK(hi, ON_US[c - 1] / 100 * DIV)
        end
        for (int c = 0; c < 5; c++) begin
            wr(A_TMR, 8'(8'h10 | c));
            // first period after a setting write is cut short by the tick phase
            to_rise(hi);
            to_rise(hi);
            to_rise(hi);
            `CHK(hi, PER_MS[c] * 10 * DIV)
        end
        // reserved period or on-time code leaves the timer stopped and low
        wr(A_TMR, 8'h17);
        cyc(3);
        `CHK({switch_output[0], second_cyclic_timer}, 2'b00)
        wr(A_TMR, 8'h71);
        cyc(3);
        `CHK({switch_output[0], second_cyclic_timer}, 2'b00)
        // a switch fault clears only that switch's field
        wr(A_LO, 8'h11);
        wr(A_HI, 8'h11);
        @(posedge aclk);
        overcurrent <= 4'h2;
        overtemp <= 4'h4;
        @(posedge aclk);
        {overcurrent, overtemp} <= '0;
        rd(A_LO, 34'h01);
        rd(A_HI, 34'h10);
        // supply faults with recovery, disabled, then without recovery
        wr(A_LO, 8'h11);
        wr(A_HI, 8'h11);
        wr(A_SD, 8'h10);
        @(posedge aclk);
        supply_uv <= 1'b1;
        cyc(3);
        `CHK(switch_output, 4'h0)
        supply_uv <= 1'b0;
        cyc(3);
        `CHK(switch_output, 4'hF)
        wr(A_SD, 8'h60);
        {supply_ov, supply_uv} <= 2'b11;
        cyc(3);
        `CHK(switch_output, 4'hF)
        {supply_ov, supply_uv} <= 2'b10;
        wr(A_SD, 8'h20);
        cyc(3);
        `CHK(switch_output, 4'h0)
        supply_ov <= 1'b0;
        cyc(3);
        `CHK(switch_output, 4'h0)
        rd(A_LO, 34'h0);
        // restart keeps the shutdown options, soft reset clears them
        wr(A_SD, 8'h70);
        wr(A_LO, 8'h11);
        wr(A_TMR, 8'h12);
        @(posedge aclk);
        {restart_mode, cyclic_sense_active} <= 2'b11;
        @(posedge aclk);
        {restart_mode, cyclic_sense_active} <= 2'b00;
        rd(A_SD, 34'h70);
        rd(A_LO, 34'h0);
        rd(A_TMR, 34'h0);
        @(posedge aclk);
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        rd(A_SD, 34'h0);
        cyc(2);
        wrap_up();
    end
endmodule // test_high_side_switch_control
